// File: slm_pkg.sv
package slm_pkg;

	// ------------------------------------------------------------
	// Register offsets.
	// ------------------------------------------------------------
	localparam logic [7:0] LOCK_CFG_OFS = 8'h28;
	localparam logic [7:0] MISC_OFS = 8'h2a;
	localparam logic [7:0] MOD_OFS = 8'h2b;
	localparam logic [7:0] CORE_OFS = 8'h2c;
	localparam logic [7:0] FRAC_LOAD_OFS = 8'h10;

	// ------------------------------------------------------------
	// Values after reset and writable bit masks.
	// ------------------------------------------------------------
	localparam logic [7:0] LOCK_CFG_RST = 8'h03;
	localparam logic [7:0] MISC_RST = 8'h00;
	localparam logic [7:0] MOD_RST = 8'h01;
	localparam logic [7:0] CORE_RST = 8'h44;
	localparam logic [7:0] LOCK_CFG_MASK = 8'h07;
	localparam logic [7:0] MISC_MASK = 8'h29;
	localparam logic [7:0] MOD_MASK = 8'h35;
	localparam logic [7:0] CORE_MASK = 8'h7f;

	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	localparam int LOSS_EN_BIT = 0;
	localparam int LCNT_LSB = 1;
	localparam int LCNT_MSB = 2;
	localparam int BLEED_POLARITY_BIT = 5;
	localparam int CS_SYNC_BIT = 3;
	localparam int READ_SEL_BIT = 0;
	localparam int HALF_LSB_BIT = 5;
	localparam int AUX_EN_BIT = 4;
	localparam int RST_MASK_BIT = 2;
	localparam int MOD_DIS_BIT = 0;
	localparam int RECT_BIT = 6;
	localparam int THR_RANGE_BIT = 5;
	localparam int THR_NOM_LSB = 2;
	localparam int THR_NOM_MSB = 4;
	localparam int TEMP_CAL_BIT = 1;
	localparam int BIAS_DIS_BIT = 0;

	// ------------------------------------------------------------
	// Counts and counter widths.
	// ------------------------------------------------------------
	localparam int LOCK_BASE_COUNT = 1024;
	localparam int LOCK_CNT_W = 14;
	localparam int REF_LOSS_CYCLES = 64;
	localparam int REF_LOSS_W = 7;

	// ------------------------------------------------------------
	// Carriers.
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} slm_bus_type;

	typedef struct packed {
		logic bleed_polarity;
		logic half_lsb_effective;
		logic aux_modulator_enable;
		logic modulator_enable;
		logic core_d_rectifier_bias_select;
		logic core_d_threshold_range;
		logic [2:0] core_d_threshold_nominal;
		logic temp_cal_voltage_enable;
		logic automatic_bias_loop_enable;
	} slm_analog_type;

endpackage

// File: slm_lock_detector.sv
`timescale 1ns/100ps
module slm_lock_detector
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic nrst,
	// Phase detector events and reference loss.
	input wire logic pfd_tick,
	input wire logic in_lock_window,
	input wire logic ref_lost,
	// Configuration.
	input wire logic [1:0] lock_count_select,
	input wire logic loss_of_lock_enable,
	// Result.
	output logic lock_detect
);

	typedef enum logic {SEARCH, LOCKED} slm_lock_state_type;

	slm_lock_state_type state;
	slm_lock_state_type next_state;
	logic [slm_pkg::LOCK_CNT_W-1:0] count;
	logic [slm_pkg::LOCK_CNT_W-1:0] next_count;
	logic [slm_pkg::LOCK_CNT_W-1:0] target;
	logic [slm_pkg::LOCK_CNT_W-1:0] count_inc;
	wire loss_drop;

	assign target = slm_pkg::LOCK_CNT_W'(slm_pkg::LOCK_BASE_COUNT)
		<< lock_count_select;
	assign count_inc = count + slm_pkg::LOCK_CNT_W'(1);
	assign loss_drop = loss_of_lock_enable && ref_lost;

	always_comb
	begin
		next_state = state;
		next_count = count;
		case (state)
			SEARCH:
			begin
				if (pfd_tick && in_lock_window)
				begin
					next_count = count_inc;
					if (count_inc >= target)
						next_state = LOCKED;
				end
				else if (pfd_tick)
					next_count = '0;
			end
			LOCKED:
			begin
				if (loss_drop || (pfd_tick && !in_lock_window))
				begin
					next_state = SEARCH;
					next_count = '0;
				end
			end
			default:
			begin
				next_state = SEARCH;
				next_count = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			state <= SEARCH;
			count <= '0;
			lock_detect <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			lock_detect <= (next_state == LOCKED);
		end
	end

endmodule

// File: slm_config_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Lock detect rises after 1024<<sel in-window ticks, sel resets to 01.
// - Lock drops on reference loss only while loss-of-lock is enabled.
// - Misc bit 5 selects negative bleed at 0 and positive bleed at 1.
// - Misc bit 3 at 1 resyncs the pin chip select to the reference edges.
// - Misc bit 0 selects oscillator data at 0 and the version code at 1.
// - With the auxiliary modulator off, the half-LSB bit adds half a bit.
// - The reset-mask bit suppresses the modulator reset of a 0x10 write.
// - Modulator disable (reset 1) turns the modulator off at 1, on at 0.
// - Core bit 6 selects rectifier bias for 3.3 V at 0 and 5 V at 1.
// - Core bit 5 selects the 5 V threshold at 0 and the 3.3 V one at 1.
// - Core bit 1 enables the temperature calibration voltage at 1.
// - Core bit 0 stops the automatic bias loop at 1.
module slm_config_regs
#(
	parameter int RB_W = 8,
	parameter logic [7:0] VERSION_ID = 8'h5a
)
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port from the serial interface.
	input wire slm_pkg::slm_bus_type reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Pins.
	input wire logic chip_select_pin,
	input wire logic reference_input_neg,
	// Phase detector.
	input wire logic pfd_tick,
	input wire logic in_lock_window,
	// Readback sources.
	input wire logic [RB_W-1:0] osc_band_bias_data,
	// Controls to the analog and modulator blocks.
	output logic lock_detect,
	output logic chip_select_out,
	output logic modulator_reset,
	output logic [RB_W-1:0] readback_data,
	output slm_pkg::slm_analog_type analog_ctrl
);

	// ------------------------------------------------------------
	// Registers and decode.
	// ------------------------------------------------------------
	logic [7:0] lock_detect_config;
	logic [7:0] misc_readback_control;
	logic [7:0] modulator_control;
	logic [7:0] core_bias_control;
	logic [7:0] next_rdata;

	wire hit_lock = reg_req.addr == slm_pkg::LOCK_CFG_OFS;
	wire hit_misc = reg_req.addr == slm_pkg::MISC_OFS;
	wire hit_mod = reg_req.addr == slm_pkg::MOD_OFS;
	wire hit_core = reg_req.addr == slm_pkg::CORE_OFS;
	wire hit_frac = reg_req.addr == slm_pkg::FRAC_LOAD_OFS;

	wire wr_lock = reg_req.wr && hit_lock;
	wire wr_misc = reg_req.wr && hit_misc;
	wire wr_mod = reg_req.wr && hit_mod;
	wire wr_core = reg_req.wr && hit_core;

	// Masking keeps reserved positions at zero in storage.
	wire [7:0] wdata_lock = reg_req.wdata & slm_pkg::LOCK_CFG_MASK;
	wire [7:0] wdata_misc = reg_req.wdata & slm_pkg::MISC_MASK;
	wire [7:0] wdata_mod = reg_req.wdata & slm_pkg::MOD_MASK;
	wire [7:0] wdata_core = reg_req.wdata & slm_pkg::CORE_MASK;

	always_comb
	begin
		next_rdata = 8'h00;
		if (hit_lock)
			next_rdata = lock_detect_config;
		else if (hit_misc)
			next_rdata = misc_readback_control;
		else if (hit_mod)
			next_rdata = modulator_control;
		else if (hit_core)
			next_rdata = core_bias_control;
	end

	// ------------------------------------------------------------
	// Register storage.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			lock_detect_config <= slm_pkg::LOCK_CFG_RST;
			misc_readback_control <= slm_pkg::MISC_RST;
			modulator_control <= slm_pkg::MOD_RST;
			core_bias_control <= slm_pkg::CORE_RST;
		end
		else
		begin
			if (wr_lock)
				lock_detect_config <= wdata_lock;
			if (wr_misc)
				misc_readback_control <= wdata_misc;
			if (wr_mod)
				modulator_control <= wdata_mod;
			if (wr_core)
				core_bias_control <= wdata_core;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd)
				reg_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Field extraction.
	// ------------------------------------------------------------
	wire [1:0] lock_count_select =
		lock_detect_config[slm_pkg::LCNT_MSB:slm_pkg::LCNT_LSB];
	wire loss_of_lock_enable = lock_detect_config[slm_pkg::LOSS_EN_BIT];
	wire bleed_polarity =
		misc_readback_control[slm_pkg::BLEED_POLARITY_BIT];
	wire chip_select_sync_enable =
		misc_readback_control[slm_pkg::CS_SYNC_BIT];
	wire read_select = misc_readback_control[slm_pkg::READ_SEL_BIT];
	wire half_lsb_add = modulator_control[slm_pkg::HALF_LSB_BIT];
	wire aux_modulator_enable = modulator_control[slm_pkg::AUX_EN_BIT];
	wire modulator_reset_mask = modulator_control[slm_pkg::RST_MASK_BIT];
	wire modulator_disable = modulator_control[slm_pkg::MOD_DIS_BIT];

	// ------------------------------------------------------------
	// Pin synchronisers.
	// ------------------------------------------------------------
	logic cs_meta;
	logic cs_sync;
	logic refin_meta;
	logic refin_sync;
	logic refin_prev;
	logic cs_held;

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			cs_meta <= 1'b0;
			cs_sync <= 1'b0;
			refin_meta <= 1'b0;
			refin_sync <= 1'b0;
			refin_prev <= 1'b0;
		end
		else
		begin
			cs_meta <= chip_select_pin;
			cs_sync <= cs_meta;
			refin_meta <= reference_input_neg;
			refin_sync <= refin_meta;
			refin_prev <= refin_sync;
		end
	end

	wire refin_edge = refin_sync && !refin_prev;

	// ------------------------------------------------------------
	// Chip select resynchronisation.
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			cs_held <= 1'b0;
		else if (refin_edge)
			cs_held <= cs_sync;
	end

	wire next_cs_out = chip_select_sync_enable ? cs_held : cs_sync;

	// ------------------------------------------------------------
	// Reference loss watch.
	// ------------------------------------------------------------
	logic [slm_pkg::REF_LOSS_W-1:0] ref_idle;

	wire ref_lost =
		ref_idle == slm_pkg::REF_LOSS_W'(slm_pkg::REF_LOSS_CYCLES);

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			ref_idle <= '0;
		else if (refin_edge)
			ref_idle <= '0;
		else if (!ref_lost)
			ref_idle <= ref_idle + slm_pkg::REF_LOSS_W'(1);
	end

	// ------------------------------------------------------------
	// Lock detector.
	// ------------------------------------------------------------
	slm_lock_detector u_lock
	(
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pfd_tick(pfd_tick),
		.in_lock_window(in_lock_window),
		.ref_lost(ref_lost),
		.lock_count_select(lock_count_select),
		.loss_of_lock_enable(loss_of_lock_enable),
		.lock_detect(lock_detect)
	);

	// ------------------------------------------------------------
	// Modulator and analog controls.
	// ------------------------------------------------------------
	wire next_mod_reset =
		reg_req.wr && hit_frac && !modulator_reset_mask;
	wire [RB_W-1:0] next_readback = read_select ?
		RB_W'(VERSION_ID) : osc_band_bias_data;

	slm_pkg::slm_analog_type next_analog;

	always_comb
	begin
		next_analog.bleed_polarity = bleed_polarity;
		next_analog.half_lsb_effective =
			half_lsb_add && !aux_modulator_enable;
		next_analog.aux_modulator_enable = aux_modulator_enable;
		next_analog.modulator_enable = !modulator_disable;
		next_analog.core_d_rectifier_bias_select =
			core_bias_control[slm_pkg::RECT_BIT];
		next_analog.core_d_threshold_range =
			core_bias_control[slm_pkg::THR_RANGE_BIT];
		next_analog.core_d_threshold_nominal =
			core_bias_control[slm_pkg::THR_NOM_MSB:slm_pkg::THR_NOM_LSB];
		next_analog.temp_cal_voltage_enable =
			core_bias_control[slm_pkg::TEMP_CAL_BIT];
		next_analog.automatic_bias_loop_enable =
			!core_bias_control[slm_pkg::BIAS_DIS_BIT];
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			chip_select_out <= 1'b0;
			modulator_reset <= 1'b0;
			readback_data <= '0;
			analog_ctrl <= '0;
		end
		else
		begin
			chip_select_out <= next_cs_out;
			modulator_reset <= next_mod_reset;
			readback_data <= next_readback;
			analog_ctrl <= next_analog;
		end
	end

endmodule

// File: slm_chk.sv
`timescale 1ns/100ps
module slm_chk
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port.
	input wire slm_pkg::slm_bus_type reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// Lock inputs and outputs, modulator reset and analog controls.
	input wire logic pfd_tick,
	input wire logic in_lock_window,
	input wire logic lock_detect,
	input wire logic modulator_reset,
	input wire slm_pkg::slm_analog_type analog_ctrl
);
	logic mask_q;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// Copy of the reset-mask bit.
	always_ff @(posedge clk_sys)
		if (!nrst)
			mask_q <= 1'b0;
		else if (reg_req.wr && reg_req.addr == 8'h2b)
			mask_q <= reg_req.wdata[2];
	sequence s_wr(a);
		reg_req.wr && reg_req.addr == a;
	endsequence
	sequence s_set(a);
		s_wr(a) ##1 !reg_req.wr ##1 1'b1;
	endsequence
	AST_LOCK_RISE: assert property (
		$rose(lock_detect) |-> $past(pfd_tick) && $past(in_lock_window))
		else $error("lock rose without tick");
	AST_MRST_GO: assert property (
		s_wr(8'h10) and !mask_q |=> modulator_reset)
		else $error("load pulse missing");
	AST_MRST_ONLY: assert property (
		modulator_reset |-> $past(reg_req.wr && reg_req.addr == 8'h10)
		&& !$past(mask_q))
		else $error("load pulse unexpected");
	AST_MOD_EN: assert property (
		s_set(8'h2b) |-> analog_ctrl.modulator_enable
		== !$past(reg_req.wdata[0], 2)) else $error("modulator enable");
	AST_BLEED: assert property (
		s_set(8'h2a) |-> analog_ctrl.bleed_polarity
		== $past(reg_req.wdata[5], 2)) else $error("bleed polarity");
	AST_BIAS: assert property (
		s_set(8'h2c) |-> analog_ctrl.automatic_bias_loop_enable
		== !$past(reg_req.wdata[0], 2)) else $error("bias loop");
	AST_RST_CTRL: assert property (
		$rose(nrst) |=> analog_ctrl == 11'h045) else $error("reset controls");
	AST_RSV: assert property (
		reg_req.rd && reg_req.addr == 8'h28 |=> reg_rvalid
		&& (reg_rdata & 8'hf8) == 8'h00) else $error("reserved bits");
endmodule
bind slm_config_regs slm_chk u_chk
(
	.clk_sys, .nrst, .reg_req, .reg_rdata, .reg_rvalid, .pfd_tick,
	.in_lock_window, .lock_detect, .modulator_reset, .analog_ctrl
);

// File: slm_host.sv
`timescale 1ns/100ps
module slm_host
(
	// Clock.
	input wire logic clk_sys,
	// Register port.
	output slm_pkg::slm_bus_type reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial reg_req = '0;
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		reg_req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_sys);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		reg_req <= '0;
		@(posedge clk_sys);
		d = reg_rdata;
		v = reg_rvalid;
	endtask
	task automatic init();
		wr(8'h28, 8'h03);
		wr(8'h2c, 8'h44);
	endtask
	task automatic frac(input logic aux_nz, frac_zero, half);
		wr(8'h2b, {2'b00, half, aux_nz, 3'b000, frac_zero});
	endtask
endmodule

// File: tb.sv
`timescale 1ns/100ps
module tb;
	localparam logic [7:0] VID = 8'h96;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic cs_pin = 1'b0;
	logic ref_in = 1'b0;
	logic pfd_tick = 1'b0;
	logic in_win = 1'b0;
	logic ref_run = 1'b1;
	logic [2:0] rcnt = 3'h0;
	logic [7:0] osc = 8'h3c;
	slm_pkg::slm_bus_type reg_req;
	logic [7:0] rdata;
	logic rvalid;
	logic lock;
	logic cs_out;
	logic mod_rst;
	logic [7:0] rb;
	slm_pkg::slm_analog_type actrl;
	int miscompares = 0;
	int cmp_count = 0;
	int n;
	logic [7:0] ofs [4] = '{8'h28, 8'h2a, 8'h2b, 8'h2c};
	logic [7:0] rstv [4] = '{8'h03, 8'h00, 8'h01, 8'h44};
	logic [7:0] msk [4] = '{8'h07, 8'h29, 8'h35, 8'h7f};
	slm_config_regs #(.RB_W(8), .VERSION_ID(VID)) u_dut
	(
		.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req),
		.reg_rdata(rdata), .reg_rvalid(rvalid), .chip_select_pin(cs_pin),
		.reference_input_neg(ref_in), .pfd_tick(pfd_tick),
		.in_lock_window(in_win), .osc_band_bias_data(osc),
		.lock_detect(lock), .chip_select_out(cs_out),
		.modulator_reset(mod_rst), .readback_data(rb), .analog_ctrl(actrl)
	);
	slm_host u_host
	(
		.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(rdata),
		.reg_rvalid(rvalid)
	);
	always #5 clk_sys = ~clk_sys;
	// Reference with a rising edge every eight clocks while running.
	always @(posedge clk_sys)
	begin
		rcnt <= rcnt + 3'h1;
		ref_in <= ref_run & rcnt[2];
	end
	task automatic tk(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic chk(input logic [15:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic rchk(input logic [7:0] a, exp, input string m);
		logic [7:0] d;
		logic v;
		u_host.rd(a, d, v);
		chk(16'(v), 16'h1, m);
		chk(16'(d), 16'(exp), m);
	endtask
	task automatic lock_up(input logic [1:0] sel);
		u_host.wr(8'h28, {5'h00, sel, 1'b1});
		n = 0;
		in_win <= 1'b0;
		pfd_tick <= 1'b1;
		@(posedge clk_sys);
		in_win <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (lock !== 1'b1 && n < 9000);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 4; i++)
			rchk(ofs[i], rstv[i], "reset value");
		chk(16'(actrl), 16'h045, "reset controls");
		for (int i = 0; i < 4; i++)
		begin
			u_host.wr(ofs[i], 8'hff);
			rchk(ofs[i], msk[i], "reserved ones");
			u_host.wr(ofs[i], 8'h00);
			rchk(ofs[i], 8'h00, "reserved zeros");
			u_host.wr(ofs[i], rstv[i]);
		end
		u_host.wr(8'h29, 8'hff);
		rchk(8'h29, 8'h00, "unmapped");
		$display("end regs");
	endtask
	task automatic t_ctrl();
		logic [7:0] a [4] = '{8'h2b, 8'h2b, 8'h2c, 8'h2a};
		logic [7:0] d [4] = '{8'h20, 8'h30, 8'h23, 8'h20};
		logic [15:0] e [4] = '{16'h2c5, 16'h1c5, 16'h1a2, 16'h5a2};
		for (int i = 0; i < 4; i++)
		begin
			u_host.wr(a[i], d[i]);
			tk(2);
			chk(16'(actrl), e[i], "controls");
		end
		u_host.frac(1'b0, 1'b1, 1'b0);
		u_host.init();
		u_host.wr(8'h2a, 8'h00);
		tk(2);
		chk(16'(actrl), 16'h045, "restored");
		$display("end ctrl");
	endtask
	task automatic t_mod();
		u_host.wr(8'h10, 8'h00);
		tk(1);
		chk(16'(mod_rst), 16'h1, "load pulse");
		tk(1);
		chk(16'(mod_rst), 16'h0, "pulse width");
		u_host.wr(8'h2b, 8'h05);
		u_host.wr(8'h10, 8'h00);
		tk(1);
		chk(16'(mod_rst), 16'h0, "masked load");
		u_host.frac(1'b0, 1'b1, 1'b0);
		$display("end mod");
	endtask
	task automatic t_cs();
		cs_pin <= 1'b1;
		tk(5);
		chk(16'(cs_out), 16'h1, "direct select");
		tk(8);
		ref_run <= 1'b0;
		u_host.wr(8'h2a, 8'h08);
		tk(10);
		cs_pin <= 1'b0;
		tk(20);
		chk(16'(cs_out), 16'h1, "no reference");
		ref_run <= 1'b1;
		tk(20);
		chk(16'(cs_out), 16'h0, "resynced");
		chk(16'(rb), 16'(osc), "readback data");
		u_host.wr(8'h2a, 8'h01);
		tk(3);
		chk(16'(rb), 16'(VID), "readback version");
		u_host.wr(8'h2a, 8'h00);
		$display("end cs");
	endtask
	task automatic t_lock();
		for (int s = 0; s < 4; s++)
		begin
			lock_up(s[1:0]);
			chk(16'(n), 16'((1024 << s) + 1), "lock count");
		end
		ref_run <= 1'b0;
		n = 0;
		while (lock === 1'b1 && n < 200)
		begin
			tk(1);
			n++;
		end
		chk(16'(n > 50 && n < 80), 16'h1, "loss delay");
		ref_run <= 1'b1;
		u_host.wr(8'h28, 8'h00);
		lock_up(2'b00);
		u_host.wr(8'h28, 8'h00);
		ref_run <= 1'b0;
		tk(150);
		chk(16'(lock), 16'h1, "loss disabled");
		$display("end lock");
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		tk(40000);
		miscompares++;
		$display("[ERR] %0t watchdog", $time);
		complete_run();
	end
	initial
	begin
		tk(12);
		nrst <= 1'b1;
		t_regs();
		t_ctrl();
		t_mod();
		t_cs();
		t_lock();
		complete_run();
	end
endmodule
